// File: acs_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module acs_core_model (
	input  wire logic       clk,       // system clock
	input  wire logic [3:0] mux_ch,    // selected channel
	input  wire logic       conv_run,  // conversion phase
	output logic      [9:0] conv_data  // raw result to the sequencer
);
	logic [9:0] lvl;
	logic       flip;

	// calibration input reads 12: 4 lsb of offset above its trimmed 8
	assign lvl = (mux_ch == 4'hF) ? 10'h00C : {mux_ch, 6'h21};

	always_ff @(posedge clk) begin
		flip <= !(flip === 1'b1);
	end

	// outside conversion the line carries junk that changes every cycle
	assign conv_data = conv_run ? lvl : (flip ? ~lvl : lvl ^ 10'h155);
endmodule : acs_core_model

`default_nettype wire

// File: acs_pkg.sv
package acs_pkg;

	// byte addresses in the die-to-die register window
	localparam logic [7:0] ADDR_CFG      = 8'h80;
	localparam logic [7:0] ADDR_STAT     = 8'h81;
	localparam logic [7:0] ADDR_SEL_HI   = 8'h82;
	localparam logic [7:0] ADDR_SEL_LO   = 8'h83;
	localparam logic [7:0] ADDR_DONE_HI  = 8'h84;
	localparam logic [7:0] ADDR_DONE_LO  = 8'h85;
	localparam logic [7:0] ADDR_RES_BASE = 8'h86;
	localparam logic [7:0] ADDR_RES_LAST = 8'hA5;

	// config field positions
	localparam int CFG_SEQ_IRQ_EN   = 7;
	localparam int CFG_REPEAT_EN    = 6;
	localparam int CFG_OFFS_COMP_EN = 5;
	localparam int CFG_ARST         = 4;
	localparam logic [7:0] CFG_WMASK = 8'hF7;

	// values after reset
	localparam logic [7:0]  CFG_RST  = 8'h00;
	localparam logic [3:0]  CNT_RST  = 4'hF;
	localparam logic [15:0] SEL_RST  = 16'h0000;
	localparam logic [15:0] DONE_RST = 16'h0000;

	// channel map
	localparam logic [15:0] CH_IMPL_MASK = 16'hDFFF;
	localparam logic [3:0]  CH_CAL       = 4'hF;
	localparam logic [3:0]  CH_FIRST_EXT = 4'h0;
	localparam logic [9:0]  CAL_EXPECT   = 10'h008;

	// converter clock cycles per phase
	localparam logic [4:0] SAMPLE_CYC = 5'd9;
	localparam logic [4:0] CONV_CYC   = 5'd18;
	localparam logic [4:0] GAP_CYC    = 5'd4;

	// prescaler terminal counts (divide minus one)
	localparam logic [3:0] DIV_TERM_10 = 4'd9;
	localparam logic [3:0] DIV_TERM_8  = 4'd7;
	localparam logic [3:0] DIV_TERM_6  = 4'd5;
	localparam logic [3:0] DIV_TERM_4  = 4'd3;
	localparam logic [3:0] DIV_TERM_2  = 4'd1;
	localparam logic [3:0] DIV_TERM_1  = 4'd0;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_SEEK = 5'b00010,
		ST_SAMP = 5'b00100,
		ST_CONV = 5'b01000,
		ST_GAP  = 5'b10000
	} acs_state_t;

endpackage : acs_pkg

// File: acs_seq.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - a set select bit includes that channel in the sequence; cleared excludes it.
// - any select write aborts the running sequence; only a high byte write restarts with new selection.
// - writing all zeros to the selection halts conversion, nothing restarts.
// - every select write clears all per-channel done flags at once.
// - byte writes start only on the high byte, channel 15 first; low byte starts nothing.
// - one read-only done flag per channel; bit 13 always reads zero.
// - byte reads of the done flags return live state, no latching.
// - results are left adjusted in bits 15..6; a wide or high byte read clears the channel's flag.
// - low byte read captures high byte for next read; high byte read clears flag.
// - inputs 0-8 external, 9-12 sense, 13 absent, 14 bandgap, 15 calibration.
// - offset compensation uses channel 15 reference expected at 8 LSB.
// - compensation needs enable bit and channel 15 in the starting write.
// - converter clock is the bus clock through a programmable prescaler.
// - each conversion is 9 sampling cycles then 18 conversion cycles.
// - before first conversion counter steps 15,0,1..14 one cycle each.
// - 4 cycles between channels; seeking next channel overlaps conversion.
// - prescaler codes divide by 10,8,6,4,2, and 1 for the rest.
// - order is 15,0,1..14; status counter shows channel being converted.
// - sequence done flag sets at sequence end; status read clears it.
// - with repeat enabled the sequence restarts after each completion.
module acs_seq
	import acs_pkg::*;
(
	input  wire logic        clk,         // system clock
	input  wire logic        rst,         // synchronous reset
	input  wire logic        ce,          // clock enable, freezes all state
	input  wire logic [7:0]  bus_addr,    // register byte address
	input  wire logic        bus_wr,      // write strobe
	input  wire logic        bus_rd,      // read strobe
	input  wire logic        bus_wide,    // 16-bit access at even address
	input  wire logic [15:0] bus_wdata,   // write data, byte in [7:0]
	output logic      [15:0] bus_rdata,   // read data
	output logic             bus_rvalid,  // read data valid pulse
	input  wire logic [9:0]  conv_data,   // raw converter core result
	output logic      [3:0]  mux_ch,      // analog multiplexer channel
	output logic             sample_en,   // sampling phase
	output logic             conv_run,    // conversion phase
	output logic             conv_tick,   // converter clock enable
	output logic             irq          // sequence done interrupt
);

	typedef struct packed {
		acs_state_t       state;
		logic [3:0]       cnt;
		logic [4:0]       ph;
		logic [3:0]       div;
		logic [7:0]       cfg;
		logic             seq_done;
		logic [15:0]      sel;
		logic [15:0]      done;
		logic [15:0][9:0] res;
		logic [9:0]       cal;
		logic             comp;
		logic [7:0]       hold;
		logic             hold_v;
		logic [15:0]      rdata;
		logic             rvalid;
	} acs_st_t;

	acs_st_t     s_q;
	acs_st_t     s_d;
	logic        tick;
	logic [3:0]  div_lim;
	logic [4:0]  nxt;
	logic [15:0] set_v;
	logic        seq_done_set;
	logic [7:0]  res_off;
	logic [3:0]  rch;
	logic        res_hit;
	logic [9:0]  comp_val;
	logic [15:0] new_sel;
	logic        start;
	logic [7:0]  wbyte;
	logic [7:0]  stat_b;

	// divide code to terminal count
	function automatic logic [3:0] div_term(input logic [2:0] code);
		case (code)
			3'b000:  div_term = DIV_TERM_10;
			3'b001:  div_term = DIV_TERM_8;
			3'b010:  div_term = DIV_TERM_6;
			3'b011:  div_term = DIV_TERM_4;
			3'b100:  div_term = DIV_TERM_2;
			default: div_term = DIV_TERM_1;
		endcase
	endfunction : div_term

	// next selected channel after c, in order 15,0,1..14
	function automatic logic [4:0] next_ch(input logic [15:0] s, input logic [3:0] c);
		logic [4:0] r;
		logic [3:0] ch;
		int         pos;
		r   = '0;
		ch  = '0;
		pos = (c == CH_CAL) ? 0 : int'(c) + 1;
		for (int k = 15; k >= 1; k--) begin
			ch = 4'(k - 1);
			if (s[ch] && k > pos) begin
				r = {1'b1, ch};
			end
		end
		next_ch = r;
	endfunction : next_ch

	// subtract measured offset, clamp to 10 bits
	function automatic logic [9:0] comp_fn(input logic [9:0] raw, input logic [9:0] cal);
		logic [11:0] d;
		d = {2'b00, raw} + {2'b00, CAL_EXPECT} - {2'b00, cal};
		if (d[11]) begin
			comp_fn = '0;
		end else if (d[10]) begin
			comp_fn = 10'h3FF;
		end else begin
			comp_fn = d[9:0];
		end
	endfunction : comp_fn

	assign div_lim = div_term(s_q.cfg[2:0]);
	assign tick = (s_q.div >= div_lim);
	assign nxt = next_ch(s_q.sel, s_q.cnt);
	assign res_off = 8'(bus_addr - ADDR_RES_BASE);
	assign rch = res_off[4:1];
	assign res_hit = (bus_addr >= ADDR_RES_BASE) && (bus_addr <= ADDR_RES_LAST);
	assign wbyte = bus_wide ? bus_wdata[15:8] : bus_wdata[7:0];
	assign stat_b = {s_q.seq_done, 3'b000, s_q.cnt};
	assign comp_val = (s_q.comp && s_q.cnt != CH_CAL) ? comp_fn(conv_data, s_q.cal) : conv_data;

	always_comb begin
		s_d = s_q;
		set_v = '0;
		seq_done_set = 1'b0;
		new_sel = s_q.sel;
		start = 1'b0;
		s_d.rvalid = 1'b0;
		s_d.div = tick ? 4'h0 : 4'(s_q.div + 4'd1);
		if (tick) begin
			case (s_q.state)
				ST_IDLE: begin
					s_d.state = ST_IDLE;
				end
				ST_SEEK: begin
					if (s_q.sel[s_q.cnt]) begin
						s_d.state = ST_SAMP;
						s_d.ph = '0;
					end else begin
						s_d.cnt = (s_q.cnt == CH_CAL) ? CH_FIRST_EXT : 4'(s_q.cnt + 4'd1);
					end
				end
				ST_SAMP: begin
					if (s_q.ph == SAMPLE_CYC - 5'd1) begin
						s_d.state = ST_CONV;
						s_d.ph = '0;
					end else begin
						s_d.ph = 5'(s_q.ph + 5'd1);
					end
				end
				ST_CONV: begin
					if (s_q.ph == CONV_CYC - 5'd1) begin
						set_v[s_q.cnt] = 1'b1;
						s_d.res[s_q.cnt] = comp_val;
						if (s_q.cnt == CH_CAL) begin
							s_d.cal = conv_data;
						end
						s_d.ph = '0;
						if (nxt[4]) begin
							s_d.state = ST_GAP;
						end else begin
							seq_done_set = 1'b1;
							if (s_q.cfg[CFG_REPEAT_EN]) begin
								s_d.state = ST_SEEK;
								s_d.cnt = CH_CAL;
							end else begin
								s_d.state = ST_IDLE;
							end
						end
					end else begin
						s_d.ph = 5'(s_q.ph + 5'd1);
					end
				end
				ST_GAP: begin
					if (s_q.ph == GAP_CYC - 5'd1) begin
						s_d.state = ST_SAMP;
						s_d.cnt = nxt[3:0];
						s_d.ph = '0;
					end else begin
						s_d.ph = 5'(s_q.ph + 5'd1);
					end
				end
				default: begin
					s_d.state = ST_IDLE;
				end
			endcase
		end
		s_d.done = (s_q.done | set_v) & CH_IMPL_MASK;
		s_d.seq_done = s_q.seq_done | seq_done_set;

		if (bus_rd) begin
			s_d.rvalid = 1'b1;
			s_d.rdata = '0;
			case (bus_addr)
				ADDR_CFG: begin
					s_d.rdata = bus_wide ? {s_q.cfg, stat_b} : {8'h00, s_q.cfg};
					if (bus_wide) begin
						s_d.seq_done = seq_done_set;
					end
				end
				ADDR_STAT: begin
					s_d.rdata = {8'h00, stat_b};
					s_d.seq_done = seq_done_set;
				end
				ADDR_SEL_HI: begin
					s_d.rdata = bus_wide ? s_q.sel : {8'h00, s_q.sel[15:8]};
				end
				ADDR_SEL_LO: begin
					s_d.rdata = {8'h00, s_q.sel[7:0]};
				end
				ADDR_DONE_HI: begin
					s_d.rdata = bus_wide ? s_q.done : {8'h00, s_q.done[15:8]};
				end
				ADDR_DONE_LO: begin
					s_d.rdata = {8'h00, s_q.done[7:0]};
				end
				default: begin
					if (res_hit && CH_IMPL_MASK[rch]) begin
						if (bus_wide) begin
							s_d.rdata = {s_q.res[rch], 6'b000000};
							s_d.done[rch] = set_v[rch];
						end else if (res_off[0]) begin
							s_d.rdata = {8'h00, s_q.res[rch][1:0], 6'b000000};
							s_d.hold = s_q.res[rch][9:2];
							s_d.hold_v = 1'b1;
						end else begin
							s_d.rdata = {8'h00, s_q.hold_v ? s_q.hold : s_q.res[rch][9:2]};
							s_d.hold_v = 1'b0;
							s_d.done[rch] = set_v[rch];
						end
					end
				end
			endcase
		end

		if (bus_wr) begin
			case (bus_addr)
				ADDR_CFG: begin
					s_d.cfg = wbyte & CFG_WMASK;
				end
				ADDR_SEL_HI: begin
					new_sel = bus_wide ? bus_wdata : {bus_wdata[7:0], s_q.sel[7:0]};
					start = 1'b1;
				end
				ADDR_SEL_LO: begin
					new_sel = {s_q.sel[15:8], bus_wdata[7:0]};
				end
				default: begin
					s_d.sel = s_q.sel;
				end
			endcase
			if (bus_addr == ADDR_SEL_HI || bus_addr == ADDR_SEL_LO) begin
				s_d.sel = new_sel & CH_IMPL_MASK;
				s_d.done = DONE_RST;
				s_d.ph = '0;
				s_d.comp = s_q.cfg[CFG_OFFS_COMP_EN] && new_sel[CH_CAL];
				if (start && (new_sel & CH_IMPL_MASK) != SEL_RST) begin
					s_d.state = ST_SEEK;
					s_d.cnt = CH_CAL;
				end else begin
					s_d.state = ST_IDLE;
				end
			end
		end

		if (s_d.cfg[CFG_ARST]) begin
			s_d.state = ST_IDLE;
			s_d.cnt = CNT_RST;
			s_d.ph = '0;
			s_d.seq_done = 1'b0;
			s_d.sel = SEL_RST;
			s_d.done = DONE_RST;
			s_d.res = '0;
			s_d.cal = '0;
			s_d.comp = 1'b0;
			s_d.hold_v = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q.state <= ST_IDLE;
			s_q.cnt <= CNT_RST;
			s_q.ph <= '0;
			s_q.div <= '0;
			s_q.cfg <= CFG_RST;
			s_q.seq_done <= 1'b0;
			s_q.sel <= SEL_RST;
			s_q.done <= DONE_RST;
			s_q.res <= '0;
			s_q.cal <= '0;
			s_q.comp <= 1'b0;
			s_q.hold <= '0;
			s_q.hold_v <= 1'b0;
			s_q.rdata <= '0;
			s_q.rvalid <= 1'b0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign bus_rdata = s_q.rdata;
	assign bus_rvalid = s_q.rvalid;
	assign mux_ch = s_q.cnt;
	assign sample_en = (s_q.state == ST_SAMP);
	assign conv_run = (s_q.state == ST_CONV);
	assign conv_tick = tick;
	assign irq = s_q.cfg[CFG_SEQ_IRQ_EN] & s_q.seq_done;

	chk_flag13_zero: assert property (@(posedge clk) disable iff (rst)
		!s_q.done[13])
		else $error("done flag of absent channel set");

	chk_write_clears: assert property (@(posedge clk) disable iff (rst)
		ce && bus_wr && (bus_addr == ADDR_SEL_HI || bus_addr == ADDR_SEL_LO) |=> s_q.done == DONE_RST)
		else $error("select write left done flags set");

	chk_zero_halts: assert property (@(posedge clk) disable iff (rst)
		ce && bus_wr && bus_wide && bus_addr == ADDR_SEL_HI && bus_wdata == SEL_RST
		|=> s_q.state == ST_IDLE && s_q.sel == SEL_RST)
		else $error("zero selection did not halt");

	chk_low_nostart: assert property (@(posedge clk) disable iff (rst)
		ce && bus_wr && bus_addr == ADDR_SEL_LO |=> s_q.state == ST_IDLE)
		else $error("low byte write started conversion");

	chk_hi_start: assert property (@(posedge clk) disable iff (rst)
		ce && bus_wr && bus_wide && bus_addr == ADDR_SEL_HI && !s_q.cfg[CFG_ARST]
		&& (bus_wdata & CH_IMPL_MASK) != SEL_RST |=> s_q.state == ST_SEEK && s_q.cnt == CH_CAL)
		else $error("select write did not restart at channel 15");

	chk_res_adjust: assert property (@(posedge clk) disable iff (rst)
		ce && bus_rd && bus_wide && res_hit && !bus_wr
		|=> s_q.rdata[5:0] == 6'b000000 && s_q.rvalid)
		else $error("result not left adjusted");

	chk_read_clears: assert property (@(posedge clk) disable iff (rst)
		ce && bus_rd && !bus_wr && bus_wide && res_hit && !set_v[rch] |=> !s_q.done[$past(rch)])
		else $error("result read kept done flag");

	chk_seqflag_read: assert property (@(posedge clk) disable iff (rst)
		ce && bus_rd && !bus_wide && bus_addr == ADDR_STAT && !seq_done_set |=> !s_q.seq_done)
		else $error("status read kept sequence flag");

	chk_sample_sel: assert property (@(posedge clk) disable iff (rst)
		s_q.state == ST_SAMP |-> s_q.sel[s_q.cnt])
		else $error("sampling an unselected channel");

	chk_phase_len: assert property (@(posedge clk) disable iff (rst)
		(s_q.state == ST_SAMP |-> s_q.ph < SAMPLE_CYC) and (s_q.state == ST_GAP |-> s_q.ph < GAP_CYC))
		else $error("phase counter overran");

	chk_div_bound: assert property (@(posedge clk) disable iff (rst)
		ce && !tick |=> s_q.div <= DIV_TERM_10)
		else $error("prescaler out of range");

endmodule : acs_seq

`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import acs_pkg::*;
	logic        clk       = 1'b0;
	logic        rst       = 1'b1;
	logic        ce        = 1'b1;
	logic [7:0]  bus_addr  = 8'h00;
	logic        bus_wr    = 1'b0;
	logic        bus_rd    = 1'b0;
	logic        bus_wide  = 1'b0;
	logic [15:0] bus_wdata = 16'h0000;
	logic [15:0] bus_rdata;
	logic        bus_rvalid;
	logic [9:0]  conv_data;
	logic [3:0]  mux_ch;
	logic        sample_en;
	logic        conv_run;
	logic        conv_tick;
	logic        irq;
	logic [15:0] rd;
	logic        rv;
	int          failures = 0;
	int          n_checks = 0;
	int          n;

	always #5 clk = ~clk;

	acs_seq DUT (.clk(clk), .rst(rst), .ce(ce), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_wide(bus_wide), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
		.conv_data(conv_data), .mux_ch(mux_ch), .sample_en(sample_en), .conv_run(conv_run),
		.conv_tick(conv_tick), .irq(irq));

	acs_core_model core (.clk(clk), .mux_ch(mux_ch), .conv_run(conv_run), .conv_data(conv_data));

	task automatic tally_and_finish;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk16

	task automatic chkn(input int got, input int exp);
		n_checks++;
		if (got != exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chkn

	function automatic logic [9:0] exp_raw(input logic [3:0] ch);
		return (ch == 4'hF) ? 10'h00C : {ch, 6'h21};
	endfunction : exp_raw

	task automatic acc(input logic [7:0] a, input logic w, input logic wide, input logic [15:0] d);
		@(posedge clk);
		#1;
		bus_addr = a;
		bus_wr = w;
		bus_rd = !w;
		bus_wide = wide;
		bus_wdata = d;
		@(posedge clk);
		#1;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		rd = bus_rdata;
		rv = bus_rvalid;
	endtask : acc

	task automatic wr(input logic [7:0] a, input logic wide, input logic [15:0] d);
		acc(a, 1'b1, wide, d);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic wide, input logic [15:0] e);
		acc(a, 1'b0, wide, 16'h0000);
		chk16(rd, e);
		chk16({15'h0000, rv}, 16'h0001);
	endtask : rdc

	// edges until the phase flag reaches lvl; sel 0 sampling, 1 converting
	task automatic span(input logic sel, input logic lvl, output int k);
		k = 0;
		while (((sel ? conv_run : sample_en) !== lvl) && k < 400) begin
			@(posedge clk);
			#1;
			k++;
		end
	endtask : span

	task automatic tick_gap(output int k);
		k = 0;
		while (conv_tick !== 1'b1 && k < 40) begin
			@(posedge clk);
			#1;
			k++;
		end
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
		end while (conv_tick !== 1'b1 && k < 40);
	endtask : tick_gap

	task automatic conv_one(input int s, input logic [3:0] ch);
		span(1'b0, 1'b1, n);
		chkn(n, s);
		chk16({12'h000, mux_ch}, {12'h000, ch});
		span(1'b0, 1'b0, n);
		chkn(n, 9);
		span(1'b1, 1'b0, n);
		chkn(n, 18);
	endtask : conv_one

	task automatic t_reset;
		chk16({12'h000, mux_ch}, 16'h000F);
		rdc(ADDR_DONE_HI, 1'b1, 16'h0000);
		rdc(ADDR_CFG, 1'b1, 16'h000F);
	endtask : t_reset

	task automatic t_prescale;
		int div[8] = '{10, 8, 6, 4, 2, 1, 1, 1};
		for (int c = 0; c < 8; c++) begin
			wr(ADDR_CFG, 1'b0, {13'h0000, c[2:0]});
			tick_gap(n);
			tick_gap(n);
			chkn(n, div[c]);
		end
	endtask : t_prescale

	task automatic t_single;
		wr(ADDR_CFG, 1'b0, 16'h0085);
		wr(ADDR_SEL_HI, 1'b1, 16'h0400);
		conv_one(12, 4'hA);
		repeat (3) @(posedge clk);
		#1;
		chk16({15'h0000, irq}, 16'h0001);
		rdc(ADDR_DONE_HI, 1'b1, 16'h0400);
		rdc(ADDR_RES_BASE + 8'd20, 1'b1, {exp_raw(4'hA), 6'h00});
		rdc(ADDR_DONE_HI, 1'b1, 16'h0000);
		acc(ADDR_CFG, 1'b0, 1'b1, 16'h0000);
		chk16(rd & 16'hFF80, 16'h8580);
		chk16({15'h0000, irq}, 16'h0000);
		acc(ADDR_CFG, 1'b0, 1'b1, 16'h0000);
		chk16(rd & 16'hFF80, 16'h8500);
	endtask : t_single

	task automatic t_comp;
		wr(ADDR_CFG, 1'b0, 16'h0025);
		wr(ADDR_SEL_HI, 1'b1, 16'h8400);
		conv_one(1, 4'hF);
		conv_one(4, 4'hA);
		repeat (3) @(posedge clk);
		rdc(ADDR_RES_BASE + 8'd20, 1'b1, {exp_raw(4'hA) - 10'd4, 6'h00});
		rdc(ADDR_DONE_HI, 1'b1, 16'h8000);
		rdc(ADDR_STAT, 1'b0, 16'h008A);
		rdc(ADDR_STAT, 1'b0, 16'h000A);
	endtask : t_comp

	task automatic t_abort;
		wr(ADDR_SEL_LO, 1'b0, 16'h0001);
		rdc(ADDR_DONE_HI, 1'b1, 16'h0000);
		span(1'b0, 1'b1, n);
		chkn(n, 400);
		wr(ADDR_SEL_HI, 1'b0, 16'h0080);
		span(1'b0, 1'b1, n);
		chkn(n, 1);
		span(1'b0, 1'b0, n);
		wr(ADDR_SEL_HI, 1'b1, 16'h0002);
		conv_one(3, 4'h1);
		repeat (3) @(posedge clk);
		rdc(ADDR_DONE_HI, 1'b1, 16'h0002);
		wr(ADDR_SEL_HI, 1'b1, 16'h0002);
		span(1'b0, 1'b1, n);
		wr(ADDR_SEL_HI, 1'b1, 16'h0000);
		span(1'b0, 1'b1, n);
		chkn(n, 400);
		rdc(ADDR_DONE_HI, 1'b1, 16'h0000);
	endtask : t_abort

	task automatic t_bytes;
		logic [9:0] r;
		r = exp_raw(4'h3);
		wr(ADDR_SEL_HI, 1'b1, 16'h0008);
		conv_one(5, 4'h3);
		repeat (3) @(posedge clk);
		rdc(ADDR_DONE_LO, 1'b0, 16'h0008);
		rdc(ADDR_DONE_HI, 1'b0, 16'h0000);
		wr(ADDR_DONE_LO, 1'b0, 16'h0000);
		wr(ADDR_RES_BASE + 8'd6, 1'b1, 16'hFFFF);
		rdc(ADDR_DONE_LO, 1'b0, 16'h0008);
		rdc(ADDR_RES_BASE + 8'd7, 1'b0, {8'h00, r[1:0], 6'h00});
		rdc(ADDR_DONE_LO, 1'b0, 16'h0008);
		rdc(ADDR_RES_BASE + 8'd6, 1'b0, {8'h00, r[9:2]});
		rdc(ADDR_DONE_LO, 1'b0, 16'h0000);
	endtask : t_bytes

	task automatic t_repeat;
		wr(ADDR_CFG, 1'b0, 16'h0045);
		wr(ADDR_SEL_HI, 1'b1, 16'h0001);
		conv_one(2, 4'h0);
		span(1'b0, 1'b1, n);
		chk16({11'h000, sample_en, mux_ch}, 16'h0010);
		ce = 1'b0;
		repeat (20) @(posedge clk);
		#1;
		chk16({11'h000, sample_en, mux_ch}, 16'h0010);
		ce = 1'b1;
		wr(ADDR_CFG, 1'b0, 16'h0050);
		rdc(ADDR_CFG, 1'b1, 16'h500F);
		rdc(ADDR_SEL_HI, 1'b1, 16'h0000);
		wr(ADDR_CFG, 1'b0, 16'h0000);
		wr(ADDR_SEL_HI, 1'b1, 16'h0000);
	endtask : t_repeat

	initial begin
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		t_reset();
		t_prescale();
		t_single();
		t_comp();
		t_abort();
		t_bytes();
		t_repeat();
		tally_and_finish();
	end

	initial begin
		#100000;
		failures++;
		tally_and_finish();
	end
endmodule : testbench

`default_nettype wire
